// ===== rtl/crcm_core_regs.sv
// Function
// - Sixteen 16-bit working registers form the primary array.
// - Any working register serves as data operand, pointer or offset.
// - Register fifteen is the stack pointer, moved on interrupt entry and return.
// - Four alternate sets copy registers 0..14, not stack pointer, and persist.
// - Each alternate set binds to priority level 1..6 via a 3-bit field.
// - Swap operation selects a set; status shows current and manual set.
// - Mapped registers 0..14 access the copy of the active context.
// - All model registers are mapped and software-readable; all but PC, status and loop start are writable.
// - Program counter is 23 bits wide.
// - Instruction words are 24 bits with variable-length opcode field.
// - Prefetch register gives single-cycle issue for most instructions.
// - Hardware loops run without overhead and stay interruptible.
// - 4K-word data space split into X and Y at a boundary.
// - General instructions use X generator; dual fetches also use Y.
// - Upper 32 Kbytes map onto program memory at 16K-word pages.
// - Circular addressing in X and Y; X usable by general instructions.
// - X generator supports bit-reversed sequencing.
// - Two 40-bit accumulators plus four alternate copies.
// - Loop start registers are read-only; writes change nothing.
// - Operand handling follows six addressing modes.
`timescale 1ns/1ps
`default_nettype none
module crcm_core_regs
#(
   parameter int XY_BOUND = crcm_pkg::XY_BOUND_DEF
)
(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic [7:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire crcm_pkg::crcm_req_s core_req,
   output crcm_pkg::crcm_rsp_s    core_rsp
);
   import crcm_pkg::*;

   if (XY_BOUND <= 0 || XY_BOUND >= DS_BYTES)
   begin : g_chk
      $error("XY_BOUND out of data space");
   end

   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] wreg [0:NCTX-1][0:14];
   logic [15:0] sp;
   logic [39:0] acc_a [0:NCTX-1];
   logic [39:0] acc_b [0:NCTX-1];
   logic [2:0]  ctx;
   logic [2:0]  man_ctx;
   logic [11:0] cfg;
   logic [22:0] pc;
   logic [22:0] loop_start;
   logic [15:0] xms;
   logic [15:0] xme;
   logic [15:0] yms;
   logic [15:0] yme;
   logic [15:0] program_space_window;
   logic [2:0]  cstk [0:7];
   logic [3:0]  csp;
   crcm_rsp_s   next_rsp;
   logic [31:0] next_rdata;

   // ****************************************
   // Bus decode
   // ****************************************
   wire        bus_req  = avs_read | avs_write;
   wire        bus_wr   = avs_write & ~avs_waitrequest;
   wire        is_w     = (avs_address[7:6] == 2'b00);
   wire [3:0]  bus_idx  = avs_address[5:2];
   wire [15:0] wd       = avs_writedata[15:0];
   wire [15:0] bus_w    = (bus_idx == 4'hf) ? sp : wreg[ctx][bus_idx];

   // ****************************************
   // Operand and generator inputs
   // ****************************************
   wire [15:0] op_w = (core_req.op_idx == 4'hf) ? sp : wreg[ctx][core_req.op_idx];
   wire [15:0] x_w  = (core_req.x_idx == 4'hf) ? sp : wreg[ctx][core_req.x_idx];
   wire [15:0] y_w  = (core_req.y_idx == 4'hf) ? sp : wreg[ctx][core_req.y_idx];
   wire [15:0] x_lin = x_w + core_req.x_inc;
   wire [15:0] y_lin = y_w + core_req.y_inc;
   wire [15:0] x_len = xme - xms + 16'h0001;
   wire [15:0] y_len = yme - yms + 16'h0001;

   function automatic logic [15:0] brev(input logic [15:0] v);
      for (int i = 0; i < 16; i++)
      begin
         brev[i] = v[15-i];
      end
   endfunction : brev

   // Modulo keeps the pointer inside [start,end] for either step sign
   function automatic logic [15:0] wrap(input logic [15:0] nx, input logic neg,
                                        input logic [15:0] lo, input logic [15:0] hi,
                                        input logic [15:0] len);
      if (!neg && nx > hi)
         wrap = nx - len;
      else if (neg && nx < lo)
         wrap = nx + len;
      else
         wrap = nx;
   endfunction : wrap

   wire [15:0] x_brev = brev(brev(x_w) + brev(core_req.x_inc));
   wire [15:0] x_mod  = wrap(x_lin, core_req.x_inc[15], xms, xme, x_len);
   wire [15:0] y_mod  = wrap(y_lin, core_req.y_inc[15], yms, yme, y_len);
   wire [15:0] x_next = (core_req.x_mode == XM_BREV) ? x_brev :
                        (core_req.x_mode == XM_MOD)  ? x_mod  : x_lin;
   wire [15:0] y_next = core_req.y_mod ? y_mod : y_lin;
   wire        x_psv  = program_space_window[PSV_EN_BIT] & x_w[PSV_SEL_BIT];

   // ****************************************
   // Interrupt level to set match
   // ****************************************
   logic [NALT-1:0] lvl_hit;
   logic [2:0]      irq_ctx;
   logic            irq_sel;
   wire             lvl_ok = (core_req.irq_level != 3'h0) && (core_req.irq_level != 3'h7);
   for (genvar i = 0; i < NALT; i++)
   begin : g_lvl
      assign lvl_hit[i] = lvl_ok && (cfg[i*CFG_FW +: CFG_FW] == core_req.irq_level);
   end

   always_comb
   begin
      irq_ctx = ctx;
      irq_sel = 1'b0;
      for (int i = NALT-1; i >= 0; i--)
      begin
         if (lvl_hit[i])
         begin
            irq_ctx = 3'(i + 1);
            irq_sel = 1'b1;
         end
      end
   end

   // ****************************************
   // Register read mux
   // ****************************************
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (is_w)
         next_rdata[15:0] = bus_w;
      else
      begin
         case (avs_address)
            OFS_CFG:  next_rdata[11:0] = cfg;
            OFS_STAT:
            begin
               next_rdata[STAT_CUR_LSB +: 3] = ctx;
               next_rdata[STAT_MAN_LSB +: 3] = man_ctx;
            end
            OFS_PCL:  next_rdata[15:0] = pc[15:0];
            OFS_PCH:  next_rdata[6:0]  = pc[22:16];
            OFS_LSL:  next_rdata[15:0] = loop_start[15:0];
            OFS_LSH:  next_rdata[6:0]  = loop_start[22:16];
            OFS_AAL:  next_rdata[15:0] = acc_a[ctx][15:0];
            OFS_AAH:  next_rdata[15:0] = acc_a[ctx][31:16];
            OFS_AAU:  next_rdata[7:0]  = acc_a[ctx][39:32];
            OFS_ABL:  next_rdata[15:0] = acc_b[ctx][15:0];
            OFS_ABH:  next_rdata[15:0] = acc_b[ctx][31:16];
            OFS_ABU:  next_rdata[7:0]  = acc_b[ctx][39:32];
            OFS_XMS:  next_rdata[15:0] = xms;
            OFS_XME:  next_rdata[15:0] = xme;
            OFS_YMS:  next_rdata[15:0] = yms;
            OFS_YME:  next_rdata[15:0] = yme;
            OFS_PSV:  next_rdata[15:0] = program_space_window;
            default:  next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Core response
   // ****************************************
   always_comb
   begin
      next_rsp = core_rsp;
      next_rsp.pc = pc;
      next_rsp.ctx = ctx;
      next_rsp.sp = sp;
      next_rsp.acc_a = acc_a[ctx];
      next_rsp.acc_b = acc_b[ctx];
      next_rsp.x_valid = core_req.x_go;
      next_rsp.y_valid = core_req.y_go;
      next_rsp.instr_valid = core_req.fetch_valid;
      if (core_req.fetch_valid)
         next_rsp.instr = core_req.fetch_word;
      case (core_req.mode)
         AM_LIT:  next_rsp.operand = core_req.lit;
         AM_RDIR: next_rsp.operand = op_w;
         AM_RIND: next_rsp.ea = op_w;
         AM_MDIR: next_rsp.ea = core_req.lit;
         AM_REL:  next_rsp.target = pc + {{7{core_req.lit[15]}}, core_req.lit};
         default: next_rsp.operand = core_rsp.operand;
      endcase
      if (core_req.x_go)
      begin
         next_rsp.x_addr = x_w;
         next_rsp.psv_hit = x_psv;
         next_rsp.prog_addr = {program_space_window[7:0], x_w[14:0]};
      end
      if (core_req.y_go)
      begin
         next_rsp.y_addr = y_w;
         next_rsp.y_ok = (32'(y_w) >= XY_BOUND) && (32'(y_w) < DS_BYTES);
      end
   end

   // ****************************************
   // Bus handshake: one wait cycle per access
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         core_rsp <= '0;
      end
      else
      begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         if (avs_read & avs_waitrequest)
            avs_readdata <= next_rdata;
         core_rsp <= next_rsp;
      end
   end

   // ****************************************
   // Working registers and accumulators
   // ****************************************
   // Later assignments win: frame move, bus, then pointer update, then core write
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         for (int c = 0; c < NCTX; c++)
         begin
            for (int r = 0; r < 15; r++)
               wreg[c][r] <= 16'h0000;
            acc_a[c] <= 40'h00_0000_0000;
            acc_b[c] <= 40'h00_0000_0000;
         end
         sp <= SP_RST;
      end
      else
      begin
         // Frame move comes first so any explicit stack pointer write that cycle wins
         if (core_req.irq_take)
            sp <= sp + SP_FRAME;
         else if (core_req.irq_ret)
            sp <= sp - SP_FRAME;
         if (bus_wr && is_w)
         begin
            if (bus_idx == 4'hf)
               sp <= wd;
            else
               wreg[ctx][bus_idx] <= wd;
         end
         if (bus_wr)
         begin
            case (avs_address)
               OFS_AAL: acc_a[ctx][15:0]  <= wd;
               OFS_AAH: acc_a[ctx][31:16] <= wd;
               OFS_AAU: acc_a[ctx][39:32] <= wd[7:0];
               OFS_ABL: acc_b[ctx][15:0]  <= wd;
               OFS_ABH: acc_b[ctx][31:16] <= wd;
               OFS_ABU: acc_b[ctx][39:32] <= wd[7:0];
               default: ;
            endcase
         end
         if (core_req.y_go)
         begin
            if (core_req.y_idx == 4'hf)
               sp <= y_next;
            else
               wreg[ctx][core_req.y_idx] <= y_next;
         end
         if (core_req.x_go)
         begin
            if (core_req.x_idx == 4'hf)
               sp <= x_next;
            else
               wreg[ctx][core_req.x_idx] <= x_next;
         end
         if (core_req.wr_en)
         begin
            if (core_req.wr_idx == 4'hf)
               sp <= core_req.wr_data;
            else
               wreg[ctx][core_req.wr_idx] <= core_req.wr_data;
         end
         if (core_req.acc_wr && !core_req.acc_sel)
            acc_a[ctx] <= core_req.acc_data;
         if (core_req.acc_wr && core_req.acc_sel)
            acc_b[ctx] <= core_req.acc_data;
      end
   end

   // ****************************************
   // Context, program counter, control
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         ctx <= 3'h0;
         man_ctx <= 3'h0;
         csp <= 4'h0;
         for (int i = 0; i < 8; i++)
            cstk[i] <= 3'h0;
         cfg <= CFG_RST;
         pc <= PC_RST;
         loop_start <= PC_RST;
         xms <= MOD_RST;
         xme <= MOD_RST;
         yms <= MOD_RST;
         yme <= MOD_RST;
         program_space_window <= MOD_RST;
      end
      else
      begin
         // Loops never mask entry, so a take may land mid-loop
         if (core_req.irq_take)
         begin
            if (csp != 4'h8)
            begin
               cstk[csp[2:0]] <= ctx;
               csp <= csp + 4'h1;
            end
            if (irq_sel)
               ctx <= irq_ctx;
         end
         else if (core_req.irq_ret && csp != 4'h0)
         begin
            ctx <= cstk[csp[2:0] - 3'h1];
            csp <= csp - 4'h1;
         end
         else if (core_req.swap && core_req.swap_idx <= 3'(NALT))
         begin
            ctx <= core_req.swap_idx;
            man_ctx <= core_req.swap_idx;
         end
         if (core_req.pc_load)
            pc <= core_req.pc_value;
         else if (core_req.pc_step)
            pc <= pc + PC_STEP;
         if (core_req.do_start)
            loop_start <= pc;
         if (bus_wr)
         begin
            // Loop start offsets are absent here so writes there are dropped
            case (avs_address)
               OFS_CFG: cfg <= avs_writedata[11:0];
               OFS_XMS: xms <= wd;
               OFS_XME: xme <= wd;
               OFS_YMS: yms <= wd;
               OFS_YME: yme <= wd;
               OFS_PSV: program_space_window <= wd;
               default: ;
            endcase
         end
      end
   end
endmodule : crcm_core_regs
`default_nettype wire

// ===== rtl/crcm_pkg.sv
package crcm_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int DW      = 16;
   localparam int PCW     = 23;
   localparam int IW      = 24;
   localparam int ACW     = 40;
   localparam int NALT    = 4;
   localparam int NCTX    = 5;
   localparam int CFG_FW  = 3;
   localparam int DS_BYTES = 8192;
   localparam int XY_BOUND_DEF = 4096;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_W0   = 8'h00;
   localparam logic [7:0] OFS_CFG  = 8'h40;
   localparam logic [7:0] OFS_STAT = 8'h44;
   localparam logic [7:0] OFS_PCL  = 8'h48;
   localparam logic [7:0] OFS_PCH  = 8'h4c;
   localparam logic [7:0] OFS_LSL  = 8'h50;
   localparam logic [7:0] OFS_LSH  = 8'h54;
   localparam logic [7:0] OFS_AAL  = 8'h58;
   localparam logic [7:0] OFS_AAH  = 8'h5c;
   localparam logic [7:0] OFS_AAU  = 8'h60;
   localparam logic [7:0] OFS_ABL  = 8'h64;
   localparam logic [7:0] OFS_ABH  = 8'h68;
   localparam logic [7:0] OFS_ABU  = 8'h6c;
   localparam logic [7:0] OFS_XMS  = 8'h70;
   localparam logic [7:0] OFS_XME  = 8'h74;
   localparam logic [7:0] OFS_YMS  = 8'h78;
   localparam logic [7:0] OFS_YME  = 8'h7c;
   localparam logic [7:0] OFS_PSV  = 8'h80;
   // ****************************************
   // Fields, reset values, steps
   // ****************************************
   localparam int STAT_CUR_LSB = 0;
   localparam int STAT_MAN_LSB = 8;
   localparam int PSV_EN_BIT   = 15;
   localparam int PSV_SEL_BIT  = 15;
   localparam logic [11:0]  CFG_RST = 12'h000;
   localparam logic [15:0]  SP_RST  = 16'h1000;
   localparam logic [22:0]  PC_RST  = 23'h000000;
   localparam logic [15:0]  MOD_RST = 16'h0000;
   localparam logic [22:0]  PC_STEP = 23'h000002;
   localparam logic [15:0]  SP_FRAME = 16'h0004;
   typedef enum logic [2:0] {AM_INH, AM_REL, AM_LIT, AM_MDIR, AM_RDIR, AM_RIND} crcm_amode_e;
   typedef enum logic [1:0] {XM_LIN, XM_MOD, XM_BREV} crcm_xmode_e;
   typedef struct packed {
      logic        wr_en;
      logic [3:0]  wr_idx;
      logic [15:0] wr_data;
      crcm_amode_e mode;
      logic [3:0]  op_idx;
      logic [15:0] lit;
      logic        irq_take;
      logic [2:0]  irq_level;
      logic        irq_ret;
      logic        swap;
      logic [2:0]  swap_idx;
      logic        pc_load;
      logic        pc_step;
      logic [22:0] pc_value;
      logic        do_start;
      logic        acc_wr;
      logic        acc_sel;
      logic [39:0] acc_data;
      logic        fetch_valid;
      logic [23:0] fetch_word;
      logic        x_go;
      crcm_xmode_e x_mode;
      logic [3:0]  x_idx;
      logic [15:0] x_inc;
      logic        y_go;
      logic        y_mod;
      logic [3:0]  y_idx;
      logic [15:0] y_inc;
   } crcm_req_s;
   typedef struct packed {
      logic [15:0] operand;
      logic [15:0] ea;
      logic [22:0] target;
      logic [22:0] pc;
      logic [23:0] instr;
      logic        instr_valid;
      logic [2:0]  ctx;
      logic [15:0] sp;
      logic [15:0] x_addr;
      logic        x_valid;
      logic        psv_hit;
      logic [22:0] prog_addr;
      logic [15:0] y_addr;
      logic        y_valid;
      logic        y_ok;
      logic [39:0] acc_a;
      logic [39:0] acc_b;
   } crcm_rsp_s;
endpackage : crcm_pkg

// ===== tb/crcm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module crcm_core_model
(
   input  wire logic               ref_clk,
   output var crcm_pkg::crcm_req_s core_req
);
   import crcm_pkg::*;
   initial core_req = '0;
   // ****************************************
   // Issue
   // ****************************************
   // The core samples every edge, so a request stands for exactly one edge
   task automatic go(input crcm_req_s r);
      @(posedge ref_clk);
      core_req <= r;
      @(posedge ref_clk);
      core_req <= '0;
      #1;
   endtask : go
endmodule : crcm_core_model
`default_nettype wire

// ===== tb/crcm_core_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module crcm_core_regs_chk
   import crcm_pkg::*;
#(
   parameter int XY_BOUND = crcm_pkg::XY_BOUND_DEF
)
(
   input wire logic                ref_clk,
   input wire logic                nrst,
   input wire logic [7:0]          avs_address,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic [31:0]         avs_writedata,
   input wire logic [31:0]         avs_readdata,
   input wire logic                avs_waitrequest,
   input wire crcm_pkg::crcm_req_s core_req,
   input wire crcm_pkg::crcm_rsp_s core_rsp
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request got no answer");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   a_x_pulse: assert property (core_req.x_go |=> core_rsp.x_valid)
      else $error("x generator gave no address");
   a_y_pulse: assert property (core_req.y_go |=> core_rsp.y_valid)
      else $error("y generator gave no address");
   a_instr_word: assert property (core_req.fetch_valid |=> core_rsp.instr_valid && core_rsp.instr == $past(core_req.fetch_word))
      else $error("fetched word not issued");
   a_pc_load: assert property (core_req.pc_load |=> ##1 core_rsp.pc == $past(core_req.pc_value, 2))
      else $error("pc load lost");
   // Response copies of pc, sp, ctx and accumulators trail the state by one edge
   a_pc_step: assert property (core_req.pc_step && !core_req.pc_load
      |=> ##1 core_rsp.pc == $past(core_rsp.pc) + PC_STEP) else $error("pc step wrong");
   a_sp_enter: assert property (core_req.irq_take && !core_req.wr_en && !avs_write
      && !core_req.x_go && !core_req.y_go |=> ##1 core_rsp.sp == $past(core_rsp.sp) + SP_FRAME)
      else $error("stack pointer not moved on entry");
   a_ctx_bound: assert property (core_rsp.ctx <= 3'd4)
      else $error("context index out of range");
   a_swap_sel: assert property (core_req.swap && core_req.swap_idx <= 3'd4 && !core_req.irq_take && !core_req.irq_ret
      |=> ##1 core_rsp.ctx == $past(core_req.swap_idx, 2)) else $error("manual swap not taken");
   a_acc_load: assert property (core_req.acc_wr && !core_req.acc_sel && !core_req.irq_take && !core_req.irq_ret
      && !core_req.swap && !avs_write |=> ##1 core_rsp.acc_a == $past(core_req.acc_data, 2)) else $error("acc write lost");
endmodule : crcm_core_regs_chk
bind crcm_core_regs crcm_core_regs_chk #(.XY_BOUND(XY_BOUND)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_req(core_req), .core_rsp(core_rsp));
`default_nettype wire

// ===== tb/crcm_core_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crcm_core_regs_tb;
   import crcm_pkg::*;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} crcm_row_s;
   logic        ref_clk;
   logic        nrst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   crcm_req_s   core_req;
   crcm_rsp_s   core_rsp;
   crcm_req_s   r;
   logic [31:0] q;
   int          bad_count = 0;
   int          n_checks = 0;
   // Read rows carry the expected value in the data column
   crcm_row_s   rows [12] = '{'{0, 8'h3c, 32'h1000}, '{1, 8'h0c, 32'h1234}, '{0, 8'h0c, 32'h1234},
      '{1, 8'h40, 32'hffff}, '{0, 8'h40, 32'h0fff}, '{1, 8'h44, 32'h0707}, '{0, 8'h44, 32'h0},
      '{1, 8'h84, 32'h5a5a}, '{0, 8'h84, 32'h0}, '{1, 8'h60, 32'h1ff}, '{0, 8'h60, 32'hff}, '{0, 8'h48, 32'h0}};
   crcm_core_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_req(core_req), .core_rsp(core_rsp));
   crcm_core_model core_u (.ref_clk(ref_clk), .core_req(core_req));
   initial
   begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // State-derived response fields trail the state by one edge
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(40'(q), 40'(e));
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      nrst = 0;
      avs_address = 0;
      avs_read = 0;
      avs_write = 0;
      avs_writedata = 0;
      r = '0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1;
      foreach (rows[i])
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         else
            rd(rows[i].a, rows[i].d);
      wr(8'h04, 32'haaaa);
      r.swap = 1;
      r.swap_idx = 3'd2;
      core_u.go(r);
      rd(8'h44, 32'h0202);
      rd(8'h04, 32'h0);
      wr(8'h04, 32'h5555);
      r.swap_idx = 3'd5;
      core_u.go(r);
      tick();
      chk(40'(core_rsp.ctx), 40'h2);
      r.swap_idx = 3'd0;
      core_u.go(r);
      rd(8'h04, 32'haaaa);
      r.swap_idx = 3'd2;
      core_u.go(r);
      rd(8'h04, 32'h5555);
      wr(8'h40, 32'h3);
      r = '0;
      r.irq_take = 1;
      r.irq_level = 3'd3;
      core_u.go(r);
      tick();
      chk(40'(core_rsp.ctx), 40'h1);
      chk(40'(core_rsp.sp), 40'h1004);
      r = '0;
      r.irq_ret = 1;
      core_u.go(r);
      tick();
      chk(40'(core_rsp.ctx), 40'h2);
      chk(40'(core_rsp.sp), 40'h1000);
      r = '0;
      r.pc_load = 1;
      r.pc_value = 23'h123456;
      core_u.go(r);
      r = '0;
      r.pc_step = 1;
      r.fetch_valid = 1;
      r.fetch_word = 24'habcdef;
      core_u.go(r);
      tick();
      chk(40'(core_rsp.pc), 40'h123458);
      chk(40'(core_rsp.instr), 40'habcdef);
      r = '0;
      r.do_start = 1;
      r.acc_wr = 1;
      r.acc_data = 40'h123456789a;
      core_u.go(r);
      tick();
      chk(core_rsp.acc_a, 40'h123456789a);
      r.do_start = 0;
      r.acc_sel = 1;
      r.acc_data = 40'hfedcba9876;
      core_u.go(r);
      tick();
      chk(core_rsp.acc_b, 40'hfedcba9876);
      chk(core_rsp.acc_a, 40'h123456789a);
      rd(8'h5c, 32'h3456);
      wr(8'h50, 32'hffff);
      rd(8'h50, 32'h3458);
      rd(8'h54, 32'h12);
      wr(8'h70, 32'h100);
      wr(8'h74, 32'h107);
      wr(8'h08, 32'h106);
      r = '0;
      r.x_go = 1;
      r.x_mode = XM_MOD;
      r.x_idx = 4'd2;
      r.x_inc = 16'h2;
      core_u.go(r);
      chk(40'(core_rsp.x_addr), 40'h106);
      rd(8'h08, 32'h100);
      wr(8'h10, 32'h0);
      r.x_mode = XM_BREV;
      r.x_idx = 4'd4;
      r.x_inc = 16'h8;
      core_u.go(r);
      core_u.go(r);
      chk(40'(core_rsp.x_addr), 40'h8);
      rd(8'h10, 32'h4);
      wr(8'h80, 32'h8005);
      wr(8'h14, 32'h8010);
      r.x_mode = XM_LIN;
      r.x_idx = 4'd5;
      r.x_inc = 16'h0;
      core_u.go(r);
      chk(40'(core_rsp.psv_hit), 40'h1);
      chk(40'(core_rsp.prog_addr), 40'h028010);
      wr(8'h18, 32'h200);
      r = '0;
      r.y_go = 1;
      r.y_idx = 4'd6;
      r.y_inc = 16'h2;
      core_u.go(r);
      chk(40'(core_rsp.y_addr), 40'h200);
      chk(40'(core_rsp.y_ok), 40'h0);
      r = '0;
      r.mode = AM_RDIR;
      r.op_idx = 4'd6;
      core_u.go(r);
      chk(40'(core_rsp.operand), 40'h202);
      r.mode = AM_LIT;
      r.lit = 16'h00ab;
      core_u.go(r);
      chk(40'(core_rsp.operand), 40'hab);
      r.mode = AM_RIND;
      core_u.go(r);
      chk(40'(core_rsp.ea), 40'h202);
      r.mode = AM_REL;
      r.lit = 16'hfffe;
      core_u.go(r);
      chk(40'(core_rsp.target), 40'h123456);
      r = '0;
      r.wr_en = 1;
      r.wr_idx = 4'd7;
      r.wr_data = 16'hbeef;
      core_u.go(r);
      rd(8'h1c, 32'hbeef);
      @(posedge ref_clk);
      nrst <= 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      rd(8'h3c, 32'h1000);
      rd(8'h04, 32'h0);
      wrap_up();
   end
   initial
   begin
      // The sequence needs well under a thousand cycles; this is a wide margin
      #100us;
      bad_count++;
      wrap_up();
   end
endmodule : crcm_core_regs_tb
`default_nettype wire
